// ==== verilog/rsso_core.sv ====
// Execution datapath for rotate, subtract and sleep instructions with a register slave
`timescale 1ns/10ps
module rsso_core import rsso_pkg::*; #(
	parameter int FILE_DEPTH = 128
) (
	input wire logic clk,
	input wire logic sys_rst,
	// Decoder side
	input wire logic op_valid,
	output logic op_ready,
	input wire logic [2:0] op_code,
	input wire logic [6:0] op_file,
	input wire logic op_dest,
	input wire logic [7:0] op_lit,
	// Power and watchdog side
	input wire logic wake_pin,
	output logic watchdog_clear,
	output logic osc_halt,
	// AXI4-Lite slave
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// Elaboration check: the 7-bit file field reaches exactly 128 registers
	if (FILE_DEPTH != 128) begin : g_depth_chk
		$error("FILE_DEPTH must be 128 to match the 7-bit file field");
	end

	// Byte sum with carry in; used for the full byte and the low nibble
	function automatic logic [8:0] sum9(input logic [7:0] a, input logic [7:0] b, input logic ci);
		sum9 = {1'b0, a} + {1'b0, b} + {8'h00, ci};
	endfunction

	//------------------------------------------------------------
	// State
	//------------------------------------------------------------
	logic [7:0] file_mem [FILE_DEPTH];
	logic [7:0] acc_q;
	logic c_q, hc_q, z_q, slp_q, exp_q;
	rsso_pwr_e pwr_q;
	logic wake_m_q, wake_s_q;
	logic wdc_q;
	logic bvalid_q, rvalid_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;

	//------------------------------------------------------------
	// Instruction datapath
	//------------------------------------------------------------
	wire asleep = (pwr_q == PWR_SLEEP);
	wire op_fire = op_valid && op_ready;
	wire [7:0] file_rd = file_mem[op_file];
	wire is_rot = (op_code == OP_ROTR);
	wire is_lsub = (op_code == OP_LSUB);
	wire is_fsub = (op_code == OP_FSUB);
	wire is_fsubb = (op_code == OP_FSUBB);
	wire is_sleep = (op_code == OP_SLEEP);
	wire is_sub = is_lsub || is_fsub || is_fsubb;

	// Subtraction as a plus inverted accumulator plus carry-in; borrow is inverted carry
	wire [7:0] sub_a = is_lsub ? op_lit : file_rd;
	wire sub_ci = is_fsubb ? c_q : 1'b1;
	wire [8:0] sub_full = sum9(sub_a, ~acc_q, sub_ci);
	wire [8:0] sub_nib = sum9({4'h0, sub_a[3:0]}, {4'h0, ~acc_q[3:0]}, sub_ci);
	wire [7:0] rot_res = {c_q, file_rd[7:1]};
	wire [7:0] res = is_rot ? rot_res : sub_full[7:0];
	// Carry out of a subtract means no borrow, i.e. accumulator plus inverted sub_ci not above operand
	wire new_c = is_rot ? file_rd[0] : sub_full[8];
	wire new_hc = sub_nib[4];
	wire new_z = (sub_full[7:0] == 8'h00);
	// Literal form always lands in the accumulator
	wire to_file = op_fire && (is_rot || is_fsub || is_fsubb) && op_dest;
	wire to_acc = op_fire && (is_lsub || ((is_rot || is_fsub || is_fsubb) && !op_dest));

	assign op_ready = !asleep;
	assign osc_halt = asleep;
	assign watchdog_clear = wdc_q;

	//------------------------------------------------------------
	// Register bus decode
	//------------------------------------------------------------
	// A bus write waits for a cycle with no instruction so the two never collide
	wire bw_fire = s_axi_awvalid && s_axi_wvalid && !bvalid_q && !op_fire;
	wire br_fire = s_axi_arvalid && !rvalid_q;
	assign s_axi_awready = bw_fire;
	assign s_axi_wready = bw_fire;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;

	wire w_lo = s_axi_wstrb[0];
	wire w_acc = bw_fire && (s_axi_awaddr == ACC_OFS);
	wire w_stat = bw_fire && (s_axi_awaddr == STAT_OFS);
	wire w_ctrl = bw_fire && (s_axi_awaddr == CTRL_OFS);
	wire w_file = bw_fire && (s_axi_awaddr[11:9] == FILE_WIN) && (s_axi_awaddr[1:0] == 2'h0);
	wire w_hit = w_acc || w_stat || w_ctrl || w_file;
	wire r_file = (s_axi_araddr[11:9] == FILE_WIN) && (s_axi_araddr[1:0] == 2'h0);
	wire r_hit = r_file || (s_axi_araddr == ACC_OFS) || (s_axi_araddr == STAT_OFS)
		|| (s_axi_araddr == CTRL_OFS);
	wire [7:0] stat_rd = {2'h0, asleep, exp_q, slp_q, z_q, hc_q, c_q};
	wire [7:0] rd_byte = r_file ? file_mem[s_axi_araddr[8:2]] :
		(s_axi_araddr == ACC_OFS) ? acc_q :
		(s_axi_araddr == STAT_OFS) ? stat_rd : 8'h00;

	// Wake from the pin or from software while asleep
	wire wake_evt = asleep && (wake_s_q || (w_ctrl && w_lo && s_axi_wdata[CTRL_WAKE]));

	//------------------------------------------------------------
	// File registers; memory carries no reset
	//------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (to_file) begin
			file_mem[op_file] <= res;
		end else if (w_file && w_lo) begin
			file_mem[s_axi_awaddr[8:2]] <= s_axi_wdata[7:0];
		end
	end

	// Accumulator
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			acc_q <= ACC_RST;
		end else if (to_acc) begin
			acc_q <= res;
		end else if (w_acc && w_lo) begin
			acc_q <= s_axi_wdata[7:0];
		end
	end

	// Arithmetic flags; rotate touches only carry
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			c_q <= 1'b0;
			hc_q <= 1'b0;
			z_q <= 1'b0;
		end else if (op_fire && (is_rot || is_sub)) begin
			c_q <= new_c;
			hc_q <= is_sub ? new_hc : hc_q;
			z_q <= is_sub ? new_z : z_q;
		end else if (w_stat && w_lo) begin
			c_q <= s_axi_wdata[ST_C];
			hc_q <= s_axi_wdata[ST_HC];
			z_q <= s_axi_wdata[ST_Z];
		end
	end

	// Power-status flags; software cannot write them
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			slp_q <= SLP_RST;
			exp_q <= EXP_RST;
			wdc_q <= 1'b0;
		end else begin
			wdc_q <= op_fire && is_sleep;
			if (op_fire && is_sleep) begin
				slp_q <= 1'b0;
				exp_q <= 1'b1;
			end
		end
	end

	// Wake pin synchroniser
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wake_m_q <= 1'b0;
			wake_s_q <= 1'b0;
		end else begin
			wake_m_q <= wake_pin;
			wake_s_q <= wake_m_q;
		end
	end

	// Power state machine
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pwr_q <= PWR_RUN;
		end else begin
			case (pwr_q)
				PWR_RUN: begin
					if (op_fire && is_sleep) pwr_q <= PWR_SLEEP;
				end
				PWR_SLEEP: begin
					if (wake_evt) pwr_q <= PWR_RUN;
				end
				default: pwr_q <= PWR_RUN;
			endcase
		end
	end

	// Bus responses; unmapped addresses answer SLVERR
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			rvalid_q <= 1'b0;
			rresp_q <= RESP_OKAY;
			rdata_q <= 32'h0000_0000;
		end else begin
			if (bw_fire) begin
				bvalid_q <= 1'b1;
				bresp_q <= w_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
			if (br_fire) begin
				rvalid_q <= 1'b1;
				rresp_q <= r_hit ? RESP_OKAY : RESP_SLVERR;
				rdata_q <= {24'h00_0000, rd_byte};
			end else if (s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	//------------------------------------------------------------
	// Assertions
	//------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence s_sleep_op;
		op_fire && is_sleep;
	endsequence
	sequence s_halted;
		osc_halt && !op_ready;
	endsequence

	a_rotate_through_c: assert property (
		op_fire && is_rot && !op_dest |=> acc_q == {$past(c_q), $past(file_rd[7:1])}
			&& c_q == $past(file_rd[0]))
		else $error("rotate result or carry wrong");
	a_rotate_keep_acc: assert property (
		op_fire && is_rot && op_dest |=> acc_q == $past(acc_q))
		else $error("rotate to file changed accumulator");
	a_lit_sub_carry: assert property (
		op_fire && is_lsub |=> c_q == ($past(acc_q) <= $past(op_lit))
			&& hc_q == ($past(acc_q[3:0]) <= $past(op_lit[3:0])))
		else $error("literal subtract carry wrong");
	a_lit_sub_acc: assert property (
		op_fire && is_lsub |=> acc_q == 8'($past(op_lit) - $past(acc_q)))
		else $error("literal subtract result wrong");
	a_sleep_status: assert property (
		s_sleep_op |=> !slp_q && exp_q)
		else $error("sleep status bits wrong");
	a_sleep_wdt_clear: assert property (
		s_sleep_op |=> watchdog_clear ##1 !watchdog_clear)
		else $error("watchdog clear pulse missing");
	a_sleep_halts: assert property (
		s_sleep_op |=> s_halted)
		else $error("sleep did not halt");
	a_file_sub_carry: assert property (
		op_fire && is_fsub |=> c_q == ($past(acc_q) <= $past(file_rd))
			&& z_q == ($past(file_rd) == $past(acc_q)))
		else $error("file subtract flags wrong");
	a_file_sub_dest: assert property (
		op_fire && is_fsub && op_dest |=> acc_q == $past(acc_q))
		else $error("file subtract to file changed accumulator");
	a_borrow_sub_acc: assert property (
		op_fire && is_fsubb && !op_dest
			|=> acc_q == 8'($past(file_rd) - $past(acc_q) - 8'(!$past(c_q))))
		else $error("borrow subtract result wrong");
	a_borrow_keep_acc: assert property (
		op_fire && is_fsubb && op_dest |=> acc_q == $past(acc_q))
		else $error("borrow subtract to file changed accumulator");
	a_rotate_keep_z: assert property (
		op_fire && is_rot |=> z_q == $past(z_q) && hc_q == $past(hc_q))
		else $error("rotate disturbed zero or half carry");
	// Flag checks worked out from comparisons, independent of the adder
	a_file_sub_hc: assert property (
		op_fire && is_fsub |=> hc_q == ($past(acc_q[3:0]) <= $past(file_rd[3:0])))
		else $error("file subtract half carry wrong");
	a_borrow_sub_c: assert property (
		op_fire && is_fsubb |=> c_q == (({1'b0, $past(acc_q)} + {8'h00, !$past(c_q)})
			<= {1'b0, $past(file_rd)}))
		else $error("borrow subtract carry wrong");
	a_lit_sub_zero: assert property (
		op_fire && is_lsub |=> z_q == ($past(op_lit) == $past(acc_q)))
		else $error("literal subtract zero flag wrong");
	// While asleep only a bus write may move the accumulator
	a_asleep_keep_acc: assert property (
		asleep && !w_acc |=> acc_q == $past(acc_q))
		else $error("accumulator changed while asleep");
	// Either wake source must bring the core back to run on the next edge
	a_wake_pin_runs: assert property (
		asleep && wake_s_q |=> op_ready && !osc_halt)
		else $error("pin wake did not restore run state");
	a_wake_ctrl_runs: assert property (
		asleep && w_ctrl && w_lo && s_axi_wdata[CTRL_WAKE] |=> op_ready)
		else $error("control wake did not restore run state");
endmodule // rsso_core

// ==== verilog/rsso_pkg.sv ====
// Constants for the rotate, subtract and sleep execution block
//------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------
// Summary of operation
// - Rotate moves file register right through carry; old carry enters bit 7.
// - Rotate destination bit 0 writes accumulator, 1 writes file register back.
// - Literal minus accumulator; carry clears when accumulator is larger, half carry when its low nibble is larger.
// - Literal subtraction writes accumulator and updates carry, half carry, zero.
// - Sleep clears the sleep-entered flag and sets the expiry flag.
// - Sleep clears the watchdog counter and its prescaler.
// - Sleep halts the oscillator; no instruction runs until wake-up.
// - File minus accumulator; carry, half carry by comparison; zero updated.
// - File subtraction destination bit 0 writes accumulator, 1 writes file register.
// - Borrow subtraction takes file minus accumulator minus inverted carry; flags updated.
// - Borrow subtraction destination bit 0 writes accumulator, 1 writes file register.
package rsso_pkg;
	// Instruction codes presented by the decoder
	localparam logic [2:0] OP_ROTR = 3'h1;
	localparam logic [2:0] OP_LSUB = 3'h2;
	localparam logic [2:0] OP_FSUB = 3'h3;
	localparam logic [2:0] OP_FSUBB = 3'h4;
	localparam logic [2:0] OP_SLEEP = 3'h5;
	// Register bus layout, byte addresses
	localparam int ADDR_W = 12;
	localparam logic [11:0] ACC_OFS = 12'h000;
	localparam logic [11:0] STAT_OFS = 12'h004;
	localparam logic [11:0] CTRL_OFS = 12'h008;
	localparam logic [2:0] FILE_WIN = 3'h2; // Address bits 11:9, window 0x400-0x5fc
	// Status and control register fields
	localparam int ST_C = 0;
	localparam int ST_HC = 1;
	localparam int ST_Z = 2;
	localparam int ST_SLP = 3;
	localparam int ST_EXP = 4;
	localparam int ST_ASLEEP = 5;
	localparam int CTRL_WAKE = 0;
	// Reset values
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic SLP_RST = 1'b1;
	localparam logic EXP_RST = 1'b1;
	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Power state, one-hot
	typedef enum logic [1:0] {
		PWR_RUN = 2'b01,
		PWR_SLEEP = 2'b10
	} rsso_pwr_e;
endpackage

// ==== verification/rsso_core_tb_top.sv ====
// Self-checking bench for the rotate, subtract and sleep execution block
`timescale 1ns/10ps
module rsso_core_tb_top import rsso_pkg::*; ;
	logic clk, sys_rst, op_valid, op_ready, op_dest, wake_pin, watchdog_clear, osc_halt;
	logic [2:0] op_code;
	logic [6:0] op_file;
	logic [7:0] op_lit;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [1:0] bresp, rresp;
	int failures = 0;
	int checks_done = 0;
	rsso_core rsso_core_inst (.clk(clk), .sys_rst(sys_rst), .op_valid(op_valid),
		.op_ready(op_ready), .op_code(op_code), .op_file(op_file), .op_dest(op_dest),
		.op_lit(op_lit), .wake_pin(wake_pin), .watchdog_clear(watchdog_clear),
		.osc_halt(osc_halt), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	//------------------------------------------------------------
	// Shared tasks
	//------------------------------------------------------------
	// Compare and count; four-state equality so an unknown matches only an unknown in the same bit
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Bus write: address and data offered together, held until taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		#1;
		while (!(awready && wready)) begin
			@(posedge clk);
			#1;
		end
		@(posedge clk);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		#1;
		while (!bvalid) begin
			@(posedge clk);
			#1;
		end
		r = bresp;
		@(posedge clk);
		bready <= 1'b0;
	endtask
	// Bus read, response code and data taken once rvalid is seen, one edge before the handshake edge
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		#1;
		while (!arready) begin
			@(posedge clk);
			#1;
		end
		@(posedge clk);
		arvalid <= 1'b0;
		#1;
		while (!rvalid) begin
			@(posedge clk);
			#1;
		end
		d = rdata;
		r = rresp;
		@(posedge clk);
		rready <= 1'b0;
	endtask
	task automatic wrk(input logic [11:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
	endtask
	function automatic logic [11:0] fadr(input logic [6:0] n);
		return {FILE_WIN, n, 2'b00};
	endfunction
	// Instruction offered after an edge and dropped at the edge that takes it
	task automatic do_op(input logic [2:0] c, input logic [6:0] f, input logic d,
			input logic [7:0] k);
		@(posedge clk);
		op_valid <= 1'b1;
		op_code <= c;
		op_file <= f;
		op_dest <= d;
		op_lit <= k;
		#1;
		while (!op_ready) begin
			@(posedge clk);
			#1;
		end
		@(posedge clk);
		op_valid <= 1'b0;
	endtask
	// Expected {zero, half carry, carry, difference}; carry set means no borrow was needed
	function automatic logic [10:0] sub_exp(input logic [7:0] a, b, input logic cin);
		logic [7:0] dif;
		logic [8:0] need;
		logic [4:0] need_lo;
		dif = a - b - {7'h00, !cin};
		need = {1'b0, b} + {8'h00, !cin};
		need_lo = {1'b0, b[3:0]} + {4'h0, !cin};
		return {dif == 8'h00, need_lo <= {1'b0, a[3:0]}, need <= {1'b0, a}, dif};
	endfunction
	// Load operands, run one subtract, then read accumulator, file and flags back
	task automatic arith(input logic [2:0] c, input logic [7:0] f, w, input logic cin,
			input logic d, input logic [7:0] k);
		logic [10:0] e;
		logic [31:0] v;
		logic [1:0] r;
		wrk(ACC_OFS, {24'h0, w});
		wrk(STAT_OFS, {31'h0, cin});
		wrk(fadr(7'h2a), {24'h0, f});
		do_op(c, 7'h2a, d, k);
		e = sub_exp((c == OP_LSUB) ? k : f, w, (c == OP_FSUBB) ? cin : 1'b1);
		rd(ACC_OFS, v, r);
		chk(v, {24'h0, (d && c != OP_LSUB) ? w : e[7:0]});
		rd(fadr(7'h2a), v, r);
		chk(v, {24'h0, (d && c != OP_LSUB) ? e[7:0] : f});
		rd(STAT_OFS, v, r);
		chk(v & 32'h7, {29'h0, e[10:8]});
	endtask
	//------------------------------------------------------------
	// Scenarios
	//------------------------------------------------------------
	task automatic t_rotate;
		logic [31:0] v;
		logic [1:0] r;
		wrk(fadr(7'h05), 32'he6);
		wrk(STAT_OFS, 32'h1);
		do_op(OP_ROTR, 7'h05, 1'b0, 8'h00);
		rd(ACC_OFS, v, r);
		chk(v, 32'hf3);
		rd(fadr(7'h05), v, r);
		chk(v, 32'he6);
		rd(STAT_OFS, v, r);
		chk(v & 32'h7, 32'h0);
		wrk(fadr(7'h7f), 32'h01);
		wrk(STAT_OFS, 32'h2);
		do_op(OP_ROTR, 7'h7f, 1'b1, 8'h00);
		rd(fadr(7'h7f), v, r);
		chk(v, 32'h00);
		rd(ACC_OFS, v, r);
		chk(v, 32'hf3);
		rd(STAT_OFS, v, r);
		chk(v & 32'h7, 32'h3);
		$display("test rotate done");
	endtask
	task automatic t_lsub;
		arith(OP_LSUB, 8'h00, 8'h03, 1'b0, 1'b0, 8'h05);
		arith(OP_LSUB, 8'h00, 8'h05, 1'b1, 1'b1, 8'h03);
		arith(OP_LSUB, 8'h00, 8'h07, 1'b0, 1'b0, 8'h07);
		arith(OP_LSUB, 8'h00, 8'h01, 1'b0, 1'b0, 8'h10);
		$display("test literal subtract done");
	endtask
	task automatic t_fsub;
		arith(OP_FSUB, 8'h80, 8'h80, 1'b0, 1'b0, 8'h00);
		arith(OP_FSUB, 8'h12, 8'h2f, 1'b1, 1'b1, 8'h00);
		arith(OP_FSUB, 8'hff, 8'h0e, 1'b0, 1'b1, 8'h00);
		arith(OP_FSUBB, 8'h10, 8'h0f, 1'b0, 1'b0, 8'h00);
		arith(OP_FSUBB, 8'h10, 8'h0f, 1'b1, 1'b1, 8'h00);
		arith(OP_FSUBB, 8'h00, 8'h00, 1'b0, 1'b1, 8'h00);
		$display("test file subtract done");
	endtask
	task automatic t_sleep;
		logic [31:0] a, v;
		logic [1:0] r;
		do_op(OP_SLEEP, 7'h00, 1'b0, 8'h00);
		#1;
		chk(watchdog_clear, 1);
		chk({osc_halt, op_ready}, 2'b10);
		@(posedge clk);
		#1;
		chk(watchdog_clear, 0);
		rd(STAT_OFS, v, r);
		chk(v & 32'h38, 32'h30);
		rd(ACC_OFS, a, r);
		// An instruction offered while asleep stays held and runs only after wake-up
		op_code <= OP_LSUB;
		op_lit <= 8'h77;
		op_valid <= 1'b1;
		repeat (4) @(posedge clk);
		rd(ACC_OFS, v, r);
		chk(v, a);
		wake_pin <= 1'b1;
		#1;
		while (!op_ready) begin
			@(posedge clk);
			#1;
		end
		chk({osc_halt, op_ready}, 2'b01);
		@(posedge clk);
		op_valid <= 1'b0;
		wake_pin <= 1'b0;
		rd(ACC_OFS, v, r);
		chk(v, (32'h77 - a) & 32'hff);
		repeat (4) @(posedge clk);
		do_op(OP_SLEEP, 7'h00, 1'b0, 8'h00);
		wrk(CTRL_OFS, 32'h1);
		#1;
		chk({osc_halt, op_ready}, 2'b01);
		$display("test sleep done");
	endtask
	// Unmapped and misaligned places answer with an error and read zero
	task automatic t_bus;
		logic [31:0] v;
		logic [1:0] r;
		rd(12'h00c, v, r);
		chk(v, 32'h0);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		rd(12'h002, v, r);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		wr(12'h600, 32'h5a, r);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		$display("test bus errors done");
	endtask
	//------------------------------------------------------------
	// Run control
	//------------------------------------------------------------
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Free-running 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Watchdog: the whole sequence needs a few hundred cycles
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		close_out();
	end
	// Main sequence
	initial begin
		logic [31:0] v;
		logic [1:0] r;
		{sys_rst, op_valid, op_code, op_file, op_dest, op_lit, wake_pin} = {1'b1, 21'h0};
		{awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = 61'h0;
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		rd(STAT_OFS, v, r);
		chk(v, 32'h18);
		t_rotate();
		t_lsub();
		t_fsub();
		t_sleep();
		t_bus();
		close_out();
	end
endmodule // rsso_core_tb_top
